// ===== code_fifo.v
// Purpose: Key-code buffer, flip-flop storage addressed by index.
// Assumes: Pop and push come from the same clock domain.
// Notes:   A push into a full buffer is dropped and flagged.
`timescale 1ns/1ps
`default_nettype none

module code_fifo #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         pclk,     // Bus clock
  input  wire         presetn,  // Async reset, active low
  input  wire         push,     // Write a code
  input  wire [7:0]   din,      // Code in
  input  wire         pop,      // Remove oldest
  output wire [7:0]   dout,     // Oldest code
  output wire         empty,    // No entries
  output wire         full,     // No room
  output wire         drop,     // Push refused this cycle
  output reg  [AW:0]  count     // Entries held
);

  reg [7:0]    mem [0:DEPTH-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;

  assign empty = (count == {(AW+1){1'b0}});
  assign full  = (count == DEPTH[AW:0]);
  assign dout  = mem[rp];
  assign drop  = push && full;

  wire do_push = push && !full;
  wire do_pop  = pop && !empty;

  always @(posedge pclk) begin
    if (do_push)
      mem[wp] <= din;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp    <= {AW{1'b0}};
      rp    <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_push)
        wp <= wp + {{(AW-1){1'b0}}, 1'b1};
      if (do_pop)
        rp <= rp + {{(AW-1){1'b0}}, 1'b1};
      if (do_push && !do_pop)
        count <= count + {{AW{1'b0}}, 1'b1};
      else if (do_pop && !do_push)
        count <= count - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule // code_fifo

`default_nettype wire

// ===== key_matrix.sv
// Purpose: Passive key switch matrix in front of the scanner.
// Assumes: Rows have pull-downs; a closed key on a high column pulls its row
//          high.
// Notes:   Key index in pressed is col*ROWS+row.
`timescale 1ns/1ps
`default_nettype none
module key_matrix #(
  parameter ROWS = 8,
  parameter COLS = 20
) (
  input  wire logic [COLS-1:0]      col_out, // Column drive
  input  wire logic [ROWS*COLS-1:0] pressed, // Closed keys
  output var  logic [ROWS-1:0]      row_in   // Row lines
);
  // Open rows sit at the pull-down; a high column lifts its closed rows
  always_comb begin
    row_in = '0;
    for (int c = 0; c < COLS; c++) begin
      for (int r = 0; r < ROWS; r++) begin
        if (pressed[c*ROWS+r] && col_out[c]) row_in[r] = 1'b1;
      end
    end
  end
endmodule // key_matrix
`default_nettype wire

// ===== key_matrix_scanner.v
// Purpose: Autonomous key matrix scanner with an APB register port.
// Assumes: pclk at 125 MHz; scan steps run at a 128 kHz tick rate.
// Notes:   One column is driven high at a time while scanning; a closed key pulls its row
//          high against the row pull-down.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "key_scan_map.vh"

module key_matrix_scanner #(
  parameter ROWS     = `KS_MAX_ROWS,
  parameter COLS     = `KS_MAX_COLS,
  parameter DEPTH    = `KS_BUF_DEPTH,
  parameter TICK_CYC = `KS_TICK_CYC
) (
  input  wire            pclk,      // APB clock
  input  wire            presetn,   // Async reset, active low
  input  wire            psel,      // APB select
  input  wire            penable,   // APB access phase
  input  wire            pwrite,    // APB direction
  input  wire [11:0]     paddr,     // APB byte address
  input  wire [31:0]     pwdata,    // APB write data
  output reg  [31:0]     prdata,    // APB read data
  output reg             pready,    // APB ready
  output reg             pslverr,   // APB error
  input  wire [ROWS-1:0] row_in,    // Row pins
  output reg  [COLS-1:0] col_out,   // Column drive
  output reg             clk_req    // Peripheral clock request
);

  // ------------------------------------------------------------------
  // States
  // ------------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_SCAN = 3'b010;
  localparam ST_END  = 3'b100;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  reg        enable;
  reg [3:0]  num_rows;
  reg [4:0]  num_cols;
  reg [3:0]  deb_len;
  reg [31:0] mod_codes;
  reg        ghost;
  reg        ovf;
  reg        key_seen;
  reg [2:0]  state;
  reg [2:0]  row_cnt;
  reg [4:0]  col_cnt;
  reg [7:0]  key_idx;
  reg [7:0]  row_hit;
  reg [ROWS-1:0] col_prev;
  reg        any_key;
  reg [7:0]  mod_state;
  reg [7:0]  lock_ghost;
  reg [15:0] tick_cnt;
  reg        tick;
  reg        settle;

  wire [ROWS-1:0] row_sync;
  wire [ROWS-1:0] row_clean;
  wire [7:0]      fifo_dout;
  wire            fifo_empty;
  wire            fifo_full;
  wire            fifo_drop;
  wire [4:0]      fifo_count;

  // Counts rows pressed in a column
  function [3:0] popcount;
    input [ROWS-1:0] v;
    integer i;
    begin
      popcount = 4'h0;
      for (i = 0; i < ROWS; i = i + 1)
        popcount = popcount + {3'b000, v[i]};
    end
  endfunction

  // Address decode used by reads and writes
  function is_reg;
    input [11:0] a;
    input [11:0] off;
    begin
      is_reg = (a == off);
    end
  endfunction

  // ------------------------------------------------------------------
  // Scan tick at 128 kHz
  // ------------------------------------------------------------------
  // One tick per key plus one settle tick per column keeps a full pass
  // near 1.4 ms; no ticks while the clock request is released
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else if (tick_cnt >= TICK_CYC[15:0] - 16'h0001) begin
      tick_cnt <= 16'h0000;
      tick     <= clk_req;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  row_filter #(
    .ROWS      (ROWS)
  ) u_filter (
    .pclk      (pclk),
    .presetn   (presetn),
    .deb_len   (deb_len),
    .row_pin   (row_in),
    .row_sync  (row_sync),
    .row_clean (row_clean)
  );

  // ------------------------------------------------------------------
  // Key decision for the current position
  // ------------------------------------------------------------------
  wire       apb_acc  = psel && penable;
  wire       apb_wr   = apb_acc && pwrite && pready;
  wire       apb_rd   = apb_acc && !pwrite && pready;
  // Pop only what the setup cycle reported; a push landing between setup
  // and access must not be removed unread
  wire       pop      = apb_rd && is_reg(paddr, `KS_DATA_OFF) &&
                        !prdata[8];
  wire       scanning = (state == ST_SCAN);
  wire       step     = tick && scanning && !settle;
  wire [ROWS-1:0] pressed = row_clean;
  wire       hit      = pressed[row_cnt];
  wire       last_row = (row_cnt == num_rows[2:0] - 3'h1);
  wire       last_col = (col_cnt == num_cols - 5'h01);
  wire       ghost_now = hit && row_hit[row_cnt];
  wire [1:0] mod_slot  = key_idx[1:0];
  wire       is_mod  = (mod_codes[7:0]   == key_idx) ||
                       (mod_codes[15:8]  == key_idx) ||
                       (mod_codes[23:16] == key_idx) ||
                       (mod_codes[31:24] == key_idx);
  wire       was_new = hit && !col_prev[row_cnt];
  wire       push    = step && was_new && !is_mod &&
                       !ghost_now && !lock_ghost[row_cnt];

  // ------------------------------------------------------------------
  // Scan state machine
  // ------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      row_cnt    <= 3'h0;
      col_cnt    <= 5'h00;
      key_idx    <= 8'h00;
      row_hit    <= 8'h00;
      ghost      <= 1'b0;
      any_key    <= 1'b0;
      key_seen   <= 1'b0;
      mod_state  <= 8'h00;
      lock_ghost <= 8'h00;
      col_out    <= {COLS{1'b1}};
      clk_req    <= 1'b0;
      settle     <= 1'b0;
    end else begin
      // First tick after a column change only lets the rows settle
      if (tick)
        settle <= 1'b0;
      if (!enable) begin
        state   <= ST_IDLE;
        clk_req <= 1'b0;
        col_out <= {COLS{1'b1}};
        row_hit <= 8'h00;
        key_idx <= 8'h00;
      end else begin
        case (state)
          ST_IDLE: begin
            col_out <= {COLS{1'b1}};
            row_hit <= 8'h00;
            key_idx <= 8'h00;
            row_cnt <= 3'h0;
            col_cnt <= 5'h00;
            any_key <= 1'b0;
            clk_req <= 1'b0;
            // Unfiltered rows so that a short press still wakes the clock
            if (row_sync != {ROWS{1'b0}}) begin
              clk_req <= 1'b1;
              state   <= ST_SCAN;
              col_out <= {{(COLS-1){1'b0}}, 1'b1};
              settle  <= 1'b1;
            end
          end
          ST_SCAN: begin
            if (step) begin
              key_idx <= key_idx + 8'h01;
              if (hit) begin
                any_key <= 1'b1;
                if (ghost_now) begin
                  ghost <= 1'b1;
                  lock_ghost[row_cnt] <= 1'b1;
                end
                if (is_mod)
                  mod_state[mod_slot] <= 1'b1;
              end
              if (last_row) begin
                row_cnt <= 3'h0;
                // Rows of a column with two or more hits may hide a ghost
                if (popcount(pressed) >= 4'h2)
                  row_hit <= row_hit | pressed;
                if (last_col) begin
                  state <= ST_END;
                end else begin
                  col_cnt <= col_cnt + 5'h01;
                  // Next column high, all others low
                  col_out <= {{(COLS-1){1'b0}}, 1'b1} << (col_cnt + 5'h01);
                  settle  <= 1'b1;
                end
              end else begin
                row_cnt <= row_cnt + 3'h1;
              end
            end
          end
          ST_END: begin
            col_out <= {COLS{1'b1}};
            key_seen <= any_key;
            if (any_key) begin
              state   <= ST_SCAN;
              row_cnt <= 3'h0;
              col_cnt <= 5'h00;
              key_idx <= 8'h00;
              row_hit <= 8'h00;
              any_key <= 1'b0;
              col_out <= {{(COLS-1){1'b0}}, 1'b1};
              settle  <= 1'b1;
            end else begin
              // Lockouts live until a pass finds no key at all
              state      <= ST_IDLE;
              clk_req    <= 1'b0;
              mod_state  <= 8'h00;
              lock_ghost <= 8'h00;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
      // Software clear loses to a ghost found in the same cycle
      if (apb_wr && is_reg(paddr, `KS_STATUS_OFF) && pwdata[`KS_ST_GHOST]
          && !(step && ghost_now))
        ghost <= 1'b0;
    end
  end

  // Previous-pass press map is not kept: col_prev is held all zero, so every hit counts as new
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      col_prev <= {ROWS{1'b0}};
    else
      col_prev <= {ROWS{1'b0}};
  end

  // ------------------------------------------------------------------
  // Key-code buffer
  // ------------------------------------------------------------------

  code_fifo #(
    .DEPTH (DEPTH),
    .AW    (4)
  ) u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (push),
    .din     (key_idx),
    .pop     (pop),
    .dout    (fifo_dout),
    .empty   (fifo_empty),
    .full    (fifo_full),
    .drop    (fifo_drop),
    .count   (fifo_count)
  );

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable    <= 1'b0;
      num_rows  <= `KS_ROWS_RST;
      num_cols  <= `KS_COLS_RST;
      deb_len   <= `KS_DEB_RST;
      mod_codes <= `KS_MOD_RST;
      ovf       <= 1'b0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h00000000;
    end else begin
      // One wait-free access cycle: ready follows every setup
      pready  <= psel && !pready;
      pslverr <= 1'b0;
      // A refused push beats a clear in the same cycle
      if (fifo_drop)
        ovf <= 1'b1;
      else if (apb_wr && is_reg(paddr, `KS_STATUS_OFF) && pwdata[`KS_ST_OVF])
        ovf <= 1'b0;
      if (psel && !pready) begin
        prdata <= 32'h00000000;
        // Unmapped or misaligned address: refuse and leave state alone
        if (!(is_reg(paddr, `KS_CTRL_OFF) || is_reg(paddr, `KS_STATUS_OFF) ||
              is_reg(paddr, `KS_DATA_OFF) || is_reg(paddr, `KS_MOD_OFF)))
          pslverr <= 1'b1;
        else if (!pwrite) begin
          if (is_reg(paddr, `KS_CTRL_OFF))
            prdata <= {12'h000, deb_len, 3'h0, num_cols, num_rows, 3'h0,
                       enable};
          else if (is_reg(paddr, `KS_STATUS_OFF))
            prdata <= {19'h00000, fifo_count, 3'h0, key_seen, clk_req,
                       fifo_empty, ovf, ghost};
          else if (is_reg(paddr, `KS_DATA_OFF)) begin
            // An empty buffer reads as a zero code, never a stale one
            if (fifo_empty)
              prdata <= {23'h000000, 1'b1, 8'h00};
            else
              prdata <= {23'h000000, 1'b0, fifo_dout};
          end else
            prdata <= mod_codes;
        end
      end
      if (apb_wr && is_reg(paddr, `KS_CTRL_OFF)) begin
        enable <= pwdata[`KS_CTRL_EN];
        if (pwdata[7:4] >= 4'h1 && pwdata[7:4] <= 4'h8)
          num_rows <= pwdata[7:4];
        if (pwdata[12:8] >= 5'h01 && pwdata[12:8] <= 5'h14)
          num_cols <= pwdata[12:8];
        deb_len <= pwdata[19:16];
      end
      if (apb_wr && is_reg(paddr, `KS_MOD_OFF))
        mod_codes <= pwdata;
    end
  end

endmodule // key_matrix_scanner

`default_nettype wire

// ===== key_matrix_scanner_tb.sv
// Purpose: Self-checking bench for the key matrix scanner.
// Assumes: TICK_CYC shortened to 8; matrix set to 2 rows by 3 columns.
// Notes:   Registers reached through APB tasks.
`timescale 1ns/1ps
`default_nettype none
module key_matrix_scanner_tb;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic         clk_req, er;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [7:0]   row_in;
  logic [19:0]  col_out;
  logic [159:0] pressed;
  int           fails, tests_run, cyc;

  key_matrix_scanner #(.TICK_CYC(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .row_in(row_in),
    .col_out(col_out), .clk_req(clk_req));
  key_matrix #(.ROWS(8), .COLS(20)) matrix (
    .col_out(col_out), .pressed(pressed), .row_in(row_in));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic close_out();
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_req(input logic v, input int lim);
    int n;
    n = 0;
    while (clk_req !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk("clk_req", {31'h0, v}, {31'h0, clk_req});
  endtask

  // Press a set of keys long enough for several passes, then release
  task automatic hold_keys(input logic [159:0] k, input int len);
    pressed <= k;
    wait_req(1'b1, 300);
    repeat (len) @(posedge pclk);
    pressed <= '0;
    wait_req(1'b0, 3000);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk("col_out", 32'h000FFFFF, {12'h0, col_out});
    xfer(12'h000, 1'b0, 32'h0);
    chk("ctrl", 32'h00031480, rd);
    xfer(12'h00C, 1'b0, 32'h0);
    chk("mod", 32'hFFFFFFFF, rd);
    xfer(12'h004, 1'b0, 32'h0);
    chk("status", 32'h00000004, rd);
    xfer(12'h020, 1'b0, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, rd);
  endtask

  task automatic t_disabled();
    pressed <= 160'h1;
    repeat (200) @(posedge pclk);
    chk("clk_req_off", 32'h0, {31'h0, clk_req});
    pressed <= '0;
    repeat (50) @(posedge pclk);
  endtask

  task automatic t_limits();
    xfer(12'h000, 1'b1, 32'h00030321);
    xfer(12'h000, 1'b1, 32'h00030301);
    xfer(12'h000, 1'b1, 32'h00031521);
    xfer(12'h000, 1'b0, 32'h0);
    chk("ctrl_limits", 32'h00030321, rd);
  endtask

  task automatic t_single();
    hold_keys(160'h1 << 17, 400);
    xfer(12'h008, 1'b0, 32'h0);
    chk("key_index", 32'h00000005, rd);
    for (int i = 0; i < 17 && !rd[8]; i++) begin
      xfer(12'h008, 1'b0, 32'h0);
      if (!rd[8]) chk("key_repeat", 32'h00000005, rd);
    end
    chk("drained", 32'h00000100, rd);
  endtask

  task automatic t_modifier();
    xfer(12'h00C, 1'b1, 32'hFFFFFF05);
    hold_keys(160'h1 << 17, 400);
    xfer(12'h008, 1'b0, 32'h0);
    chk("mod_unbuffered", 32'h00000100, rd);
    xfer(12'h00C, 1'b1, 32'hFFFFFFFF);
  endtask

  task automatic t_ghost();
    hold_keys(160'h103, 3000);
    xfer(12'h004, 1'b0, 32'h0);
    chk("ghost_ovf", 32'h00001003, rd);
    xfer(12'h004, 1'b1, 32'h00000003);
    xfer(12'h004, 1'b0, 32'h0);
    chk("w1c", 32'h00001000, rd);
    repeat (16) xfer(12'h008, 1'b0, 32'h0);
    xfer(12'h008, 1'b0, 32'h0);
    chk("overflow_drop", 32'h00000100, rd);
    xfer(12'h004, 1'b0, 32'h0);
    chk("status_poll", 32'h00000004, rd);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pressed = '0;
    fails = 0;
    tests_run = 0;
    cyc = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_disabled();
    t_limits();
    t_single();
    t_modifier();
    t_ghost();
    close_out();
  end
endmodule // key_matrix_scanner_tb

bind key_matrix_scanner key_scan_checker #(.ROWS(ROWS), .COLS(COLS)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .row_in(row_in),
  .col_out(col_out), .clk_req(clk_req));
`default_nettype wire

// ===== key_scan_checker.sv
// Purpose: Port-level checks on the scanner.
// Assumes: One domain on pclk, reset presetn.
// Notes:   Bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module key_scan_checker #(
  parameter ROWS = 8,
  parameter COLS = 20
) (
  input wire logic            pclk,    // Clock
  input wire logic            presetn, // Reset, active low
  input wire logic            psel,    // APB select
  input wire logic            penable, // APB enable
  input wire logic            pwrite,  // APB direction
  input wire logic [11:0]     paddr,   // APB address
  input wire logic [31:0]     pwdata,  // APB write data
  input wire logic [31:0]     prdata,  // APB read data
  input wire logic            pready,  // APB ready
  input wire logic            pslverr, // APB error
  input wire logic [ROWS-1:0] row_in,  // Rows
  input wire logic [COLS-1:0] col_out, // Columns
  input wire logic            clk_req  // Clock request
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  AST_APB_ANSWER: assert property (s_setup |=> s_access)
    else $error("no answer after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_READY_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  AST_ERR_UNMAPPED: assert property (s_access and paddr > 12'h00C |-> pslverr)
    else $error("unmapped access not refused");
  AST_ERR_MAPPED: assert property (
    s_access and paddr <= 12'h00C && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_PRDATA_HOLD: assert property (
    !$stable(prdata) |-> $past(psel && !penable))
    else $error("prdata changed outside a transfer");
  AST_IDLE_COLS: assert property (!clk_req |-> &col_out)
    else $error("columns not high while idle");
  AST_ONE_COL: assert property (!(&col_out) |-> $onehot(col_out))
    else $error("more than one column driven");
  AST_WAKE_IDLE: assert property ($rose(clk_req) |-> $past(&col_out))
    else $error("request rose outside idle");
endmodule // key_scan_checker
`default_nettype wire

// ===== key_scan_map.vh
// Purpose: Constants for the key matrix scanner: register offsets, fields,
//          reset values and timing counts.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes:   Included only by the scanner top module, not by the buffer or row filter.
//
// Overview of operation
// - Scanner logic runs from the shared 128 kHz peripheral clock when requested.
// - Clock request stays low whenever the scanner is disabled.
// - Request may drop while enabled; reasserted at once on a row press.
// - Matrix of up to 160 keys, 8 rows by 20 columns, scanned in sequence.
// - Column count 1..20 and row count 1..8 are programmed scan limits.
// - Key codes go into a 16-byte buffer.
// - Entries stay until read; on overflow further entries are dropped.
// - Any number of keys reported; ghost keys locked out in pairs.
// - Row samples are debounced and glitch filtered before use; idle wake-up uses the unfiltered synchronised rows.
// - One full 160-key pass takes about 1.4 ms at 128 kHz.
// - After reset the machine is idle and drives all columns high.
// - A row transition in idle requests the clock and starts scanning.
// - Idle clears the 8-bit row-hit register and key-index counter.
// - Row counter wraps to zero and steps column; at both limits go scan-end.
// - Key index counts each position; pressed keys match modifiers or buffer.
// - Rows OR into row-hit only when a column shows two or more hits.
// - Hit on a row already in row-hit sets the ghost status bit.
// - Scan-end rescans if any key found, else idles and drops request.
`ifndef KEY_SCAN_MAP_VH
`define KEY_SCAN_MAP_VH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define KS_CTRL_OFF     12'h000
`define KS_STATUS_OFF   12'h004
`define KS_DATA_OFF     12'h008
`define KS_MOD_OFF      12'h00C
`define KS_TICK_OFF     12'h010

// ------------------------------------------------------------------
// Fields
// ------------------------------------------------------------------
`define KS_CTRL_EN      0
`define KS_CTRL_ROWS_LO 4
`define KS_CTRL_COLS_LO 8
`define KS_CTRL_DEB_LO  16
`define KS_ST_GHOST     0
`define KS_ST_OVF       1
`define KS_ST_EMPTY     2
`define KS_ST_REQ       3
`define KS_ST_KEY       4
`define KS_ST_CNT_LO    8

// ------------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------------
`define KS_ROWS_RST     4'h8
`define KS_COLS_RST     5'h14
`define KS_DEB_RST      4'h3
`define KS_MOD_RST      32'hFFFFFFFF
`define KS_MAX_ROWS     8
`define KS_MAX_COLS     20
`define KS_BUF_DEPTH    16
`define KS_PCLK_HZ      125000000
`define KS_SCAN_HZ      128000
`define KS_TICK_CYC     ((`KS_PCLK_HZ + `KS_SCAN_HZ - 1) / `KS_SCAN_HZ)

`endif

// ===== row_filter.v
// Purpose: Synchronise and debounce the row inputs.
// Assumes: Rows are asynchronous pins, pulled low while no key closes them.
// Notes:   A row level is accepted after deb_len+1 stable clock cycles, so it
//          settles well inside the one settle tick given to each column.
`timescale 1ns/1ps
`default_nettype none

module row_filter #(
  parameter ROWS = 8
) (
  input  wire            pclk,     // Bus clock
  input  wire            presetn,  // Async reset, active low
  input  wire [3:0]      deb_len,  // Stable cycles needed, minus one
  input  wire [ROWS-1:0] row_pin,  // Raw row pins, high on a press
  output reg  [ROWS-1:0] row_sync, // Synchronised rows, unfiltered
  output reg  [ROWS-1:0] row_clean // Debounced rows
);

  reg [ROWS-1:0] meta;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= {ROWS{1'b0}};
      row_sync <= {ROWS{1'b0}};
    end else begin
      meta     <= row_pin;
      row_sync <= meta;
    end
  end

  // ------------------------------------------------------------------
  // Per-row stability counters
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ROWS; g = g + 1) begin : gen_row
      reg [3:0] cnt;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt          <= 4'h0;
          row_clean[g] <= 1'b0;
        end else if (row_sync[g] == row_clean[g]) begin
          cnt <= 4'h0;
        end else if (cnt >= deb_len) begin
          row_clean[g] <= row_sync[g];
          cnt          <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  endgenerate

endmodule // row_filter

`default_nettype wire
